// ==== src/lccr_code_to_current.sv ====
`timescale 1ns/1ps
module lccr_code_to_current #(
  parameter int unsigned CODE_W  = 10,
  parameter int unsigned CUR_W   = 22,
  parameter int unsigned STEP_UA = 2470
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [CODE_W-1:0] code,
  output logic      [CUR_W-1:0]  current_ua
);

  logic [CUR_W-1:0] current_ff;
  logic [CUR_W-1:0] nxt_current;

  // Zero code gives zero current; every step adds the same amount
  always_comb
  begin
    nxt_current = CUR_W'(code) * CUR_W'(STEP_UA);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      current_ff <= '0;
    else
      current_ff <= nxt_current;
  end

  assign current_ua = current_ff;

endmodule

// ==== src/lccr_pkg.sv ====
package lccr_pkg;

  // ****************************************************************
  // Bus geometry
  // ****************************************************************
  localparam int unsigned ADDR_W      = 12;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned STRB_W      = DATA_W / 8;
  localparam int unsigned WORD_BYTES  = 4;

  // ****************************************************************
  // Register indices; byte address is index times four
  // ****************************************************************
  localparam logic [7:0] IDX_LIMIT    = 8'h02;
  localparam logic [7:0] IDX_CH1_HIGH = 8'h03;
  localparam logic [7:0] IDX_CH1_LOW  = 8'h04;
  localparam logic [7:0] IDX_CH2_HIGH = 8'h05;
  localparam logic [7:0] IDX_CH2_LOW  = 8'h06;

  // ****************************************************************
  // Field layout and widths
  // ****************************************************************
  localparam int unsigned REG_W       = 8;
  localparam int unsigned CODE_W      = 10;
  localparam int unsigned HIGH_W      = CODE_W - REG_W;
  localparam int unsigned LIM_CH1_BIT = 0;
  localparam int unsigned LIM_CH2_BIT = 1;
  localparam int unsigned LIM_CH3_BIT = 2;
  localparam logic [CODE_W-1:0] CODE_MAX = 10'h3FF;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [REG_W-1:0]  RST_LIMIT = 8'h30;
  localparam logic [REG_W-1:0]  RST_LOW   = 8'h00;
  localparam logic [HIGH_W-1:0] RST_HIGH  = 2'h0;

  // ****************************************************************
  // Current scale: one code step in microamps
  // ****************************************************************
  localparam int unsigned CUR_W       = 22;
  localparam int unsigned CUR_STEP_UA = 2470;

  function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
    byte_addr = ADDR_W'(idx) * ADDR_W'(WORD_BYTES);
  endfunction

endpackage

// ==== src/lccr_regs.sv ====
`timescale 1ns/1ps
// Functional notes
// - Bits 2:0 of the limit register enable the transient limit of the first, second and third switch, 1 enables.
// - The first channel high register holds code bits 9:8 in its bits 1:0 and its upper bits are unused.
// - The first channel low register holds code bits 7:0, read/write, reset to zero.
// - Every code from zero to 3FF is accepted and applied to the channel current.
// - The second channel high register holds code bits 9:8 in its bits 1:0 and its upper bits are unused.
// - The second channel low register holds code bits 7:0, read/write, reset to zero.
// - Code zero means zero current and each code step adds one uniform current step.
module lccr_regs
  import lccr_pkg::*;
#(
  parameter int unsigned STEP_UA = lccr_pkg::CUR_STEP_UA
) (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [lccr_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [lccr_pkg::DATA_W-1:0]  pwdata,
  input  wire logic [lccr_pkg::STRB_W-1:0]  pstrb,
  output logic      [lccr_pkg::DATA_W-1:0]  prdata,
  output logic                              pready,
  output logic                              pslverr,
  output logic                              first_channel_limit_enable,
  output logic                              second_channel_limit_enable,
  output logic                              third_channel_limit_enable,
  output logic      [lccr_pkg::REG_W-1:0]   transient_limit_settings,
  output logic      [lccr_pkg::CODE_W-1:0]  first_channel_current_code,
  output logic      [lccr_pkg::CODE_W-1:0]  second_channel_current_code,
  output logic      [lccr_pkg::CUR_W-1:0]   first_channel_current_ua,
  output logic      [lccr_pkg::CUR_W-1:0]   second_channel_current_ua
);
  import lccr_pkg::*;

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [REG_W-1:0]  limit_ff;
  logic [HIGH_W-1:0] ch1_high_ff;
  logic [REG_W-1:0]  ch1_low_ff;
  logic [HIGH_W-1:0] ch2_high_ff;
  logic [REG_W-1:0]  ch2_low_ff;
  logic              pready_ff;
  logic              pslverr_ff;
  logic [DATA_W-1:0] prdata_ff;
  logic [CODE_W-1:0] ch1_code;
  logic [CODE_W-1:0] ch2_code;

  logic              access;
  logic              fire;
  logic              mapped;
  logic              wr_lane0;
  logic [DATA_W-1:0] nxt_prdata;

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
    hit = (addr == byte_addr(idx));
  endfunction

  function automatic logic [DATA_W-1:0] read_value(input logic [ADDR_W-1:0] addr,
                                                    input logic [REG_W-1:0]  lim,
                                                    input logic [CODE_W-1:0] c1,
                                                    input logic [CODE_W-1:0] c2);
    logic [DATA_W-1:0] v;
    v = '0;
    if (hit(addr, IDX_LIMIT))
      v = DATA_W'(lim);
    else if (hit(addr, IDX_CH1_HIGH))
      v = DATA_W'(c1[CODE_W-1:REG_W]);
    else if (hit(addr, IDX_CH1_LOW))
      v = DATA_W'(c1[REG_W-1:0]);
    else if (hit(addr, IDX_CH2_HIGH))
      v = DATA_W'(c2[CODE_W-1:REG_W]);
    else if (hit(addr, IDX_CH2_LOW))
      v = DATA_W'(c2[REG_W-1:0]);
    read_value = v;
  endfunction

  // ****************************************************************
  // APB slave: one wait state, then pready for one cycle
  // ****************************************************************
  assign access   = psel && penable;
  assign fire     = access && pready_ff;
  assign wr_lane0 = fire && pwrite && !pslverr_ff && pstrb[0];

  always_comb
  begin
    mapped = hit(paddr, IDX_LIMIT) || hit(paddr, IDX_CH1_HIGH) || hit(paddr, IDX_CH1_LOW)
          || hit(paddr, IDX_CH2_HIGH) || hit(paddr, IDX_CH2_LOW);
  end

  // Upper bits of a high register come back as zero
  always_comb
  begin
    nxt_prdata = read_value(paddr, limit_ff, ch1_code, ch2_code);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready_ff <= 1'b0;
    else
      pready_ff <= access && !pready_ff;
  end

  // Error and read data are settled one cycle before pready is sampled
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr_ff <= 1'b0;
    else if (access && !pready_ff)
      pslverr_ff <= !mapped;
    else
      pslverr_ff <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_ff <= '0;
    else if (access && !pready_ff && !pwrite)
      prdata_ff <= nxt_prdata;
    else
      prdata_ff <= '0;
  end

  // ****************************************************************
  // Register writes; only byte lane 0 carries data
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      limit_ff <= RST_LIMIT;
    else if (wr_lane0 && hit(paddr, IDX_LIMIT))
      limit_ff <= pwdata[REG_W-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ch1_high_ff <= RST_HIGH;
    else if (wr_lane0 && hit(paddr, IDX_CH1_HIGH))
      ch1_high_ff <= pwdata[HIGH_W-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ch1_low_ff <= RST_LOW;
    else if (wr_lane0 && hit(paddr, IDX_CH1_LOW))
      ch1_low_ff <= pwdata[REG_W-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ch2_high_ff <= RST_HIGH;
    else if (wr_lane0 && hit(paddr, IDX_CH2_HIGH))
      ch2_high_ff <= pwdata[HIGH_W-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ch2_low_ff <= RST_LOW;
    else if (wr_lane0 && hit(paddr, IDX_CH2_LOW))
      ch2_low_ff <= pwdata[REG_W-1:0];
  end

  // No clamp: the whole 10-bit range reaches the regulators
  assign ch1_code = {ch1_high_ff, ch1_low_ff};
  assign ch2_code = {ch2_high_ff, ch2_low_ff};

  // ****************************************************************
  // Code to current scaling
  // ****************************************************************
  lccr_code_to_current #(
    .CODE_W  (CODE_W),
    .CUR_W   (CUR_W),
    .STEP_UA (STEP_UA)
  ) u_ch1_current (
    .pclk       (pclk),
    .presetn    (presetn),
    .code       (ch1_code),
    .current_ua (first_channel_current_ua)
  );

  lccr_code_to_current #(
    .CODE_W  (CODE_W),
    .CUR_W   (CUR_W),
    .STEP_UA (STEP_UA)
  ) u_ch2_current (
    .pclk       (pclk),
    .presetn    (presetn),
    .code       (ch2_code),
    .current_ua (second_channel_current_ua)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign prdata                      = prdata_ff;
  assign pready                      = pready_ff;
  assign pslverr                     = pslverr_ff;
  assign transient_limit_settings    = limit_ff;
  assign first_channel_limit_enable  = limit_ff[LIM_CH1_BIT];
  assign second_channel_limit_enable = limit_ff[LIM_CH2_BIT];
  assign third_channel_limit_enable  = limit_ff[LIM_CH3_BIT];
  assign first_channel_current_code  = ch1_code;
  assign second_channel_current_code = ch2_code;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_LIMIT_ENABLES:
    assert property (wr_lane0 && hit(paddr, IDX_LIMIT)
                     |=> {third_channel_limit_enable, second_channel_limit_enable, first_channel_limit_enable}
                         == $past(pwdata[LIM_CH3_BIT:LIM_CH1_BIT]))
    else $error("limit enables do not follow the written bits");

  AST_CH1_HIGH_READ:
    assert property (fire && !pwrite && hit(paddr, IDX_CH1_HIGH)
                     |-> prdata == DATA_W'(ch1_code[CODE_W-1:REG_W]))
    else $error("first channel high read is wrong");

  AST_CH1_LOW_WRITE:
    assert property (wr_lane0 && hit(paddr, IDX_CH1_LOW)
                     |=> first_channel_current_code[REG_W-1:0] == $past(pwdata[REG_W-1:0]))
    else $error("first channel low write not applied");

  AST_FULL_RANGE:
    assert property (wr_lane0 && hit(paddr, IDX_CH2_HIGH) && pwdata[HIGH_W-1:0] == CODE_MAX[CODE_W-1:REG_W]
                     |=> second_channel_current_code[CODE_W-1:REG_W] == CODE_MAX[CODE_W-1:REG_W])
    else $error("top of code range not applied");

  AST_CH2_HIGH_WRITE:
    assert property (wr_lane0 && hit(paddr, IDX_CH2_HIGH)
                     |=> second_channel_current_code[CODE_W-1:REG_W] == $past(pwdata[HIGH_W-1:0]))
    else $error("second channel high write not applied");

  AST_CH2_LOW_HOLD:
    assert property (!(wr_lane0 && hit(paddr, IDX_CH2_LOW))
                     |=> second_channel_current_code[REG_W-1:0] == $past(second_channel_current_code[REG_W-1:0]))
    else $error("second channel low changed without a write");

  AST_LINEAR_CURRENT:
    assert property (##1 first_channel_current_ua
                     == CUR_W'($past(first_channel_current_code)) * CUR_W'(STEP_UA))
    else $error("first channel current not linear in code");

  AST_UPPER_ZERO:
    assert property (fire && !pwrite && (hit(paddr, IDX_CH1_HIGH) || hit(paddr, IDX_CH2_HIGH))
                     |-> prdata[DATA_W-1:HIGH_W] == '0)
    else $error("unused high bits read nonzero");

  AST_PREADY_ONE_WAIT:
    assert property (access && !pready_ff |=> pready ##1 !pready)
    else $error("pready timing broken");

  AST_UNMAPPED_ERR:
    assert property (access && !pready_ff && !mapped |=> pslverr && prdata == '0)
    else $error("unmapped access not flagged");

  AST_LIMIT_HOLD:
    assert property (!(wr_lane0 && hit(paddr, IDX_LIMIT))
                     |=> transient_limit_settings == $past(transient_limit_settings))
    else $error("limit register changed without a write");

  AST_CH1_HIGH_HOLD:
    assert property (!(wr_lane0 && hit(paddr, IDX_CH1_HIGH))
                     |=> first_channel_current_code[CODE_W-1:REG_W] == $past(first_channel_current_code[CODE_W-1:REG_W]))
    else $error("first channel high changed without a write");

  AST_STRB_REFUSED:
    assert property (fire && pwrite && !pstrb[0] && hit(paddr, IDX_CH1_LOW)
                     |=> first_channel_current_code[REG_W-1:0] == $past(first_channel_current_code[REG_W-1:0]))
    else $error("write without lane zero strobe was applied");

  AST_CH2_LOW_WRITE:
    assert property (wr_lane0 && hit(paddr, IDX_CH2_LOW)
                     |=> second_channel_current_code[REG_W-1:0] == $past(pwdata[REG_W-1:0]))
    else $error("second channel low write not applied");

  // Read data must not linger where a master might sample it late
  AST_PRDATA_IDLE:
    assert property (!pready |-> prdata == '0)
    else $error("read data present without pready");

  COV_WRITE_CH1_MAX:
    cover property (wr_lane0 && hit(paddr, IDX_CH1_HIGH) ##[1:20] first_channel_current_code == CODE_MAX);
  COV_READ_LIMIT:
    cover property (fire && !pwrite && hit(paddr, IDX_LIMIT));
  COV_UNMAPPED:
    cover property (fire && pslverr);
  COV_ALL_LIMITS_ON:
    cover property (first_channel_limit_enable && second_channel_limit_enable && third_channel_limit_enable);
  COV_STRB_OFF:
    cover property (fire && pwrite && !pstrb[0]);

endmodule

// ==== testbench/lccr_host_model.sv ====
`timescale 1ns/1ps
module lccr_host_model (
  input  wire logic                         pclk,
  output logic                              psel,
  output logic                              penable,
  output logic                              pwrite,
  output logic      [lccr_pkg::ADDR_W-1:0]  paddr,
  output logic      [lccr_pkg::DATA_W-1:0]  pwdata,
  output logic      [lccr_pkg::STRB_W-1:0]  pstrb,
  input  wire logic [lccr_pkg::DATA_W-1:0]  prdata,
  input  wire logic                         pready,
  input  wire logic                         pslverr
);
  import lccr_pkg::*;

  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = '0;
    pwdata  = '0;
    pstrb   = '0;
  end

  // ****************************************************************
  // One transfer; call just after a rising edge
  // ****************************************************************
  // Keeping psel up when last is low gives a back-to-back setup
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd,
                      input logic [STRB_W-1:0] st, input logic last,
                      output logic [DATA_W-1:0] rd, output logic err);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    pstrb   <= st;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    if (last)
    begin
      psel    <= 1'b0;
      penable <= 1'b0;
      // Released lines must not keep showing old values
      paddr   <= ~a;
      pwdata  <= ~wd;
      pstrb   <= ~st;
      @(posedge pclk);
    end
  endtask
endmodule

// ==== testbench/led_channel_current_regs_tb.sv ====
`timescale 1ns/1ps
module led_channel_current_regs_tb;
  import lccr_pkg::*;
  logic                pclk;
  logic                presetn;
  logic                psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0]   paddr;
  logic [DATA_W-1:0]   pwdata, prdata;
  logic [STRB_W-1:0]   pstrb;
  logic                en1, en2, en3;
  logic [REG_W-1:0]    lim;
  logic [CODE_W-1:0]   code1, code2;
  logic [CUR_W-1:0]    ua1, ua2;
  int                  n_errors;
  int                  checks;
  int                  cycles;

  always #12.5 pclk = ~pclk;

  lccr_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  lccr_regs #(.STEP_UA(CUR_STEP_UA)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .first_channel_limit_enable(en1), .second_channel_limit_enable(en2),
    .third_channel_limit_enable(en3), .transient_limit_settings(lim), .first_channel_current_code(code1),
    .second_channel_current_code(code2), .first_channel_current_ua(ua1), .second_channel_current_ua(ua2));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [ADDR_W-1:0] a4(input logic [7:0] idx);
    return ADDR_W'(idx) << 2;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic last);
    logic [31:0] r;
    logic        e;
    host.xfer(1'b1, a4(idx), d, 4'hF, last, r, e);
  endtask

  task automatic rd(input logic [7:0] idx, output logic [31:0] d);
    logic e;
    host.xfer(1'b0, a4(idx), 32'h0, 4'h0, 1'b1, d, e);
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic test_reset;
    logic [7:0]  idx[4];
    logic [31:0] d;
    idx = '{IDX_CH1_HIGH, IDX_CH1_LOW, IDX_CH2_HIGH, IDX_CH2_LOW};
    chk(32'({en3, en2, en1}), 32'h0);
    chk(32'(ua1), 32'h0);
    chk(32'(ua2), 32'h0);
    rd(IDX_LIMIT, d);
    chk(d, 32'h30);
    for (int i = 0; i < 4; i++)
    begin
      rd(idx[i], d);
      chk(d, 32'h0);
    end
    $display("test reset done");
  endtask

  task automatic test_limit;
    logic [31:0] d;
    for (int i = 0; i < 4; i++)
    begin
      wr(IDX_LIMIT, 32'h30 | ((32'h1 << i) & 32'h7), 1'b1);
      @(posedge pclk);
      chk(32'({en3, en2, en1}), (32'h1 << i) & 32'h7);
      chk(32'(lim), 32'h30 | ((32'h1 << i) & 32'h7));
      rd(IDX_LIMIT, d);
      chk(d, 32'h30 | ((32'h1 << i) & 32'h7));
    end
    // All three enables at once; bits above the register are dropped
    wr(IDX_LIMIT, 32'h1FF, 1'b1);
    @(posedge pclk);
    chk(32'({en3, en2, en1}), 32'h7);
    chk(32'(lim), 32'hFF);
    wr(IDX_LIMIT, 32'h30, 1'b1);
    rd(IDX_LIMIT, d);
    chk(d, 32'h30);
    $display("test limit done");
  endtask

  task automatic test_codes;
    logic [9:0]  codes[5];
    logic [31:0] d;
    codes = '{10'h000, 10'h001, 10'h155, 10'h2AA, 10'h3FF};
    for (int ch = 0; ch < 2; ch++)
    begin
      for (int i = 0; i < 5; i++)
      begin
        // Upper bits of the high register set on purpose; they must not stick
        wr(ch ? IDX_CH2_HIGH : IDX_CH1_HIGH, {24'h0, 6'h3F, codes[i][9:8]}, 1'b0);
        wr(ch ? IDX_CH2_LOW : IDX_CH1_LOW, {24'h0, codes[i][7:0]}, 1'b1);
        repeat (2) @(posedge pclk);
        chk(32'(ch ? code2 : code1), 32'(codes[i]));
        chk(32'(ch ? ua2 : ua1), 32'(codes[i]) * CUR_STEP_UA);
        rd(ch ? IDX_CH2_HIGH : IDX_CH1_HIGH, d);
        chk(d, 32'(codes[i][9:8]));
        rd(ch ? IDX_CH2_LOW : IDX_CH1_LOW, d);
        chk(d, 32'(codes[i][7:0]));
      end
    end
    $display("test codes done");
  endtask

  task automatic test_errors;
    logic [31:0] d;
    logic        e;
    host.xfer(1'b1, 12'h01C, 32'h5A, 4'hF, 1'b1, d, e);
    chk(32'(e), 32'h1);
    host.xfer(1'b0, 12'h011, 32'h0, 4'h0, 1'b1, d, e);
    chk({d[30:0], e}, 32'h1);
    wr(IDX_CH1_LOW, 32'h5A, 1'b1);
    host.xfer(1'b1, a4(IDX_CH1_LOW), 32'hA5, 4'h0, 1'b1, d, e);
    rd(IDX_CH1_LOW, d);
    chk(d, 32'h5A);
    $display("test errors done");
  endtask

  // ****************************************************************
  // Main sequence and hang guard
  // ****************************************************************
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_errors++;
      wrap_up;
    end
  end

  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    n_errors = 0;
    checks = 0;
    cycles = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    test_reset;
    test_limit;
    test_codes;
    test_errors;
    wrap_up;
  end
endmodule
